// ==== pkg/eeprom_defines.svh ====
// Shared constants of the two-wire EEPROM slave
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// Device type code expected in the top nibble of the first byte
`define DEV_TYPE_CODE 4'hA
// Byte address width of the larger density; the smaller one uses 14
`define ADDR_W_LARGE 15
// Page geometry: 64 bytes, six low address bits
`define PAGE_BYTES 64
`define PAGE_ADDR_W 6
// Bit counter values: data bits per byte and the acknowledge slot
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT 4'h9
// Write cycle time in milliseconds and the local clock period
`define T_WR_MS 5
`define CLK_PERIOD_NS 50
// Longest write time rounds down to whole clock cycles
`define WR_CYCLES ((`T_WR_MS * 1000000) / `CLK_PERIOD_NS)
// Depth of the buffer in the write data path
`define WBUF_DEPTH 2

`endif

// ==== pkg/eeprom_pkg.sv ====
// Types shared by the two-wire EEPROM slave
package eeprom_pkg;

    // Protocol states, Gray coded along the write path; ST_DEV to ST_RDATA changes two bits
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_AHI   = 3'b011,
        ST_ALO   = 3'b010,
        ST_WDATA = 3'b110,
        ST_RDATA = 3'b111,
        ST_HOLD  = 3'b101
    } proto_state_t;

endpackage

// ==== pkg/stream_if.sv ====
// Valid/ready word stream between the slave's modules
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/pair_buffer.sv ====
// Small FIFO with valid and ready on both sides
`timescale 1ns/10ps
`include "eeprom_defines.svh"
module pair_buffer #(
    parameter int W = 14,
    parameter int DEPTH = `WBUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Filling and draining sides
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] slot_q [DEPTH];
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] rptr_q;
    logic [CW-1:0] count_q;
    wire push = in_s.valid & in_s.ready;
    wire pop = out_s.valid & out_s.ready;

    // Honest full and empty
    assign in_s.ready = (count_q != CW'(DEPTH));
    assign out_s.valid = (count_q != '0);
    assign out_s.data = slot_q[rptr_q];

    // Pointer wrap that also works for depths that are not powers of two
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Storage, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            slot_q[wptr_q] <= in_s.data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wptr_q <= bump(wptr_q);
            if (pop) rptr_q <= bump(rptr_q);
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule // pair_buffer

// ==== rtl/two_wire_eeprom_slave.sv ====
// Two-wire serial EEPROM slave: protocol, page buffer, array and write cycle
`timescale 1ns/10ps
`include "eeprom_defines.svh"
module two_wire_eeprom_slave #(
    parameter int ADDR_W = `ADDR_W_LARGE,
    parameter int WR_CYCLES = `WR_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Serial bus pins; data is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Straps and protection
    input wire logic chip_select_bit2_i,
    input wire logic chip_select_bit1_i,
    input wire logic chip_select_bit0_i,
    input wire logic write_protect_i,
    // Status
    output logic write_busy_o
);
    localparam int PW = `PAGE_ADDR_W;
    localparam int WCW = $clog2(WR_CYCLES + 1);
    localparam int BUFW = PW + 8;

    eeprom_pkg::proto_state_t state_q;
    eeprom_pkg::proto_state_t state_d;

    // Two-stage pin synchronisers plus edge history taken from stage two
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;

    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] tx_q;
    logic [7:0] ahi_q;
    logic [7:0] rd_data_q;
    logic drive_q;
    logic mack_q;
    logic sda_low_q;
    logic busy_q;
    logic [WCW-1:0] wcnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-PW-1:0] page_q;
    logic [`PAGE_BYTES-1:0] mask_q;
    logic [7:0] page_buf [`PAGE_BYTES];
    logic [7:0] mem [2**ADDR_W];

    stream_if #(.W(BUFW)) wbuf_in ();
    stream_if #(.W(BUFW)) wbuf_out ();

    // Synchronised pin views
    wire scl_s = pin_sync_q[0];
    wire sda_s = pin_sync_q[1];
    wire [2:0] cs_s = pin_sync_q[4:2];
    wire wp_s = pin_sync_q[5];

    // Bus events
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire byte_end = scl_fall & (cnt_q == `BITS_PER_BYTE);
    wire ack_end = scl_fall & (cnt_q == `ACK_SLOT);

    // Byte decode
    // type code and strap match
    wire dev_hit = (shreg_q[7:4] == `DEV_TYPE_CODE) && (shreg_q[3:1] == cs_s);
    // no ack to address byte while programming
    wire dev_ack = byte_end && (state_q == eeprom_pkg::ST_DEV) && dev_hit && !busy_q;
    wire in_ahi = (state_q == eeprom_pkg::ST_AHI);
    wire in_alo = (state_q == eeprom_pkg::ST_ALO);
    wire in_wdata = (state_q == eeprom_pkg::ST_WDATA);
    wire in_rdata = (state_q == eeprom_pkg::ST_RDATA);
    wire alo_end = byte_end & in_alo;
    wire wr_byte = byte_end & in_wdata;
    // ack every accepted address or data byte
    wire ack_now = dev_ack | (byte_end & (in_ahi | in_alo)) | (wr_byte & wbuf_in.ready);
    // master ack fetches the next byte
    wire load_tx = ack_end & in_rdata & mack_q;
    wire tx_shift = scl_fall & in_rdata & (cnt_q != 4'h0) & (cnt_q < `BITS_PER_BYTE);
    // only the low address bits are kept
    wire [15:0] word_addr = {ahi_q, shreg_q};
    wire [ADDR_W-1:0] new_addr = word_addr[ADDR_W-1:0];
    // write-protect blocks programming; stop launches write
    wire commit = stop_det & in_wdata & (|mask_q) & ~wp_s & ~busy_q;
    wire [PW-1:0] widx = wcnt_q[PW-1:0];
    wire wr_array = busy_q && (wcnt_q < WCW'(`PAGE_BYTES)) && mask_q[widx];
    // write cycle ends after its fixed count
    wire wr_done = busy_q && (wcnt_q == WCW'(WR_CYCLES - 1));
    // start abandons a pending write, but never a running one
    wire abandon = start_det & ~busy_q;

    // Write data path: accepted bytes carry their page offset
    assign wbuf_in.valid = wr_byte;
    assign wbuf_in.data = {addr_q[PW-1:0], shreg_q};
    // Page buffer is frozen while the array is being programmed
    assign wbuf_out.ready = ~busy_q;

    pair_buffer #(.W(BUFW), .DEPTH(`WBUF_DEPTH)) u_wbuf (
        .clk_i(mclk_i),
        .srst_i(srst_i),
        .in_s(wbuf_in),
        .out_s(wbuf_out)
    );

    // Pin synchroniser chain
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_meta_q <= 6'h3F;
            pin_sync_q <= 6'h3F;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {write_protect_i, chip_select_bit2_i, chip_select_bit1_i,
                chip_select_bit0_i, sda_i, scl_i};
            pin_sync_q <= pin_meta_q;
            scl_prev_q <= pin_sync_q[0];
            sda_prev_q <= pin_sync_q[1];
        end
    end

    // Next protocol state
    always_comb begin
        state_d = state_q;
        if (start_det) begin
            // every command opens at a start
            state_d = eeprom_pkg::ST_DEV;
        end else if (stop_det) begin
            state_d = eeprom_pkg::ST_IDLE;
        end else if (byte_end) begin
            case (state_q)
                eeprom_pkg::ST_DEV: begin
                    // direction bit picks read or write
                    if (!dev_ack) state_d = eeprom_pkg::ST_IDLE;
                    else if (shreg_q[0]) state_d = eeprom_pkg::ST_RDATA;
                    else state_d = eeprom_pkg::ST_AHI;
                end
                eeprom_pkg::ST_AHI: state_d = eeprom_pkg::ST_ALO;
                eeprom_pkg::ST_ALO: state_d = eeprom_pkg::ST_WDATA;
                default: state_d = state_q;
            endcase
        end else if (ack_end && in_rdata && !mack_q) begin
            // missing master ack ends the read
            state_d = eeprom_pkg::ST_HOLD;
        end
    end

    // State register
    always_ff @(posedge mclk_i) begin
        if (srst_i) state_q <= eeprom_pkg::ST_IDLE;
        else state_q <= state_d;
    end

    // Bit counter within each nine-clock frame
    always_ff @(posedge mclk_i) begin
        if (srst_i || start_det || stop_det) begin
            cnt_q <= 4'h0;
        end else if (scl_rise && cnt_q < `BITS_PER_BYTE) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (scl_rise && cnt_q == `BITS_PER_BYTE) begin
            cnt_q <= `ACK_SLOT;
        end else if (ack_end) begin
            cnt_q <= 4'h0;
        end
    end

    // input bits and master ack taken on the clock rise
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            shreg_q <= 8'h00;
            mack_q <= 1'b0;
        end else if (scl_rise && cnt_q < `BITS_PER_BYTE) begin
            shreg_q <= {shreg_q[6:0], sda_s};
        end else if (scl_rise && cnt_q == `BITS_PER_BYTE) begin
            mack_q <= ~sda_s;
        end
    end

    // output changes after a falling clock edge, or is released at a start or stop
    always_ff @(posedge mclk_i) begin
        if (srst_i || start_det || stop_det) begin
            drive_q <= 1'b0;
        end else if (byte_end) begin
            // ack low on the ninth clock, released for master ack in reads
            drive_q <= ack_now;
        end else if (load_tx) begin
            drive_q <= ~rd_data_q[7];
        end else if (ack_end) begin
            drive_q <= 1'b0;
        end else if (tx_shift) begin
            drive_q <= ~tx_q[7];
        end
    end

    // Transmit shifter, most significant bit first
    always_ff @(posedge mclk_i) begin
        if (srst_i) tx_q <= 8'h00;
        else if (load_tx) tx_q <= {rd_data_q[6:0], 1'b0};
        else if (tx_shift) tx_q <= {tx_q[6:0], 1'b0};
    end

    // High word-address byte held until the low one arrives
    always_ff @(posedge mclk_i) begin
        if (srst_i) ahi_q <= 8'h00;
        else if (byte_end && in_ahi) ahi_q <= shreg_q;
    end

    // address counter survives commands, cleared only by reset
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            addr_q <= '0;
            page_q <= '0;
        end else if (alo_end) begin
            addr_q <= new_addr;
            page_q <= new_addr[ADDR_W-1:PW];
        end else if (wr_byte && wbuf_in.ready) begin
            // page offset rolls over, page row stays
            addr_q[PW-1:0] <= addr_q[PW-1:0] + PW'(1);
        end else if (load_tx) begin
            // full counter wraps from top of array to zero
            addr_q <= addr_q + ADDR_W'(1);
        end
    end

    // Synchronous array read so the array can map to block memory
    always_ff @(posedge mclk_i) begin
        rd_data_q <= mem[addr_q];
    end

    // page buffer collects up to a full page before stop
    always_ff @(posedge mclk_i) begin
        if (wbuf_out.valid && wbuf_out.ready) begin
            page_buf[wbuf_out.data[BUFW-1:8]] <= wbuf_out.data[7:0];
        end
    end

    // Written-byte mask; later bytes overwrite earlier ones in place
    always_ff @(posedge mclk_i) begin
        if (srst_i || wr_done || alo_end || abandon) begin
            // a new start drops the half-built page
            mask_q <= '0;
        end else if (wbuf_out.valid && wbuf_out.ready) begin
            mask_q[wbuf_out.data[BUFW-1:8]] <= 1'b1;
        end
    end

    // self-timed write, busy for a fixed count
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            busy_q <= 1'b0;
            wcnt_q <= '0;
        end else if (commit) begin
            busy_q <= 1'b1;
            wcnt_q <= '0;
        end else if (wr_done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            wcnt_q <= wcnt_q + WCW'(1);
        end
    end

    // program one page slot per cycle at the start of the write time
    always_ff @(posedge mclk_i) begin
        if (wr_array) begin
            mem[{page_q, widx}] <= page_buf[widx];
        end
    end

    // Open-drain data pin only ever pulls low
    always_ff @(posedge mclk_i) begin
        if (srst_i) sda_low_q <= 1'b0;
        else sda_low_q <= 1'b0;
    end

    assign sda_o = sda_low_q;
    assign sda_oe_o = drive_q;
    assign write_busy_o = busy_q;
endmodule // two_wire_eeprom_slave

// ==== verification/bus_master.sv ====
// Two-wire bus master model, clock parked high between frames
`timescale 1ns/10ps
module bus_master (
    // Resolved data line
    input wire logic sda_i,
    // Driven pins; data high means released
    output logic scl_o,
    output logic sda_o
);
    task automatic bit_cycle(input logic b, output logic r);
        #100 sda_o = b;
        #100 scl_o = 1'b1;
        #100 r = sda_i;
        #100 scl_o = 1'b0;
    endtask
    task automatic start();
        #300 sda_o = 1'b1;
        #200 scl_o = 1'b1;
        #200 sda_o = 1'b0;
        #200 scl_o = 1'b0;
    endtask
    // stop; late data move lets the ack drop first
    task automatic stop();
        #300 sda_o = 1'b0;
        #200 scl_o = 1'b1;
        #200 sda_o = 1'b1;
        #400;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], r);
        end
        bit_cycle(1'b1, r);
        ack = !r;
    endtask
    // byte in, ack only if more wanted
    task automatic recv(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, r);
            b[i] = r;
        end
        bit_cycle(!more, r);
    endtask
    // Idle bus
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
endmodule // bus_master

// ==== verification/eeprom_slave_properties.sv ====
// Concurrent checks on the EEPROM slave's ports
`timescale 1ns/10ps
module eeprom_slave_props #(
    parameter int ADDR_W = 15,
    parameter int WR_CYCLES = 100000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Bus pins and status
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic write_protect_i,
    input wire logic write_busy_o
);
    logic [31:0] busy_cnt_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // Length of the running write window, cleared when idle
    always_ff @(posedge mclk_i) begin
        busy_cnt_q <= (srst_i || !write_busy_o) ? 32'h0 : busy_cnt_q + 32'h1;
    end

    reset_quiet_a: assert property (disable iff (1'b0)
        srst_i |=> !sda_oe_o && !write_busy_o) else $error("outputs active after reset");
    open_drain_a: assert property (!sda_o)
        else $error("data output value not low");
    out_on_low_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
        else $error("data drive changed while clock high");
    oe_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*6])
        else $error("data drive released too early");
    busy_silent_a: assert property (write_busy_o |-> !sda_oe_o)
        else $error("line driven during write cycle");
    busy_len_a: assert property ($fell(write_busy_o) |-> busy_cnt_q == WR_CYCLES)
        else $error("write cycle length wrong");
    wp_block_a: assert property ($rose(write_busy_o) |->
        !write_protect_i && !$past(write_protect_i, 8)) else $error("write while protected");
    stop_launch_a: assert property ($rose(write_busy_o) |->
        scl_i && sda_i && $past(scl_i, 6)) else $error("write cycle without stop");

    // Main scenarios reached
    cover property ($rose(write_busy_o));
    cover property ($fell(write_busy_o));
    cover property ($fell(sda_oe_o));
endmodule // eeprom_slave_props

bind two_wire_eeprom_slave eeprom_slave_props #(.ADDR_W(ADDR_W), .WR_CYCLES(WR_CYCLES)) u_props (
    .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i), .write_busy_o(write_busy_o));

// ==== verification/tb_top.sv ====
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module tb_top;
    localparam int AW = 15;
    localparam int WRC = 200;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic protect_q = 1'b0;
    logic [2:0] straps_q = 3'b101;
    logic scl, m_sda, sda_o, sda_oe_o, write_busy_o, sda_line, ack;
    logic [7:0] rd;
    logic [7:0] ref_mem [int];
    int cur_q = 0;
    int n_mismatch = 0;
    int checks_done = 0;
    // Device byte beside expected ack
    logic [8:0] rows [6] = '{{8'hAA, 1'b1}, {8'hAB, 1'b1}, {8'hA2, 1'b0},
                             {8'hBA, 1'b0}, {8'hA9, 1'b0}, {8'h2B, 1'b0}};

    // Open-drain line with pull-up
    assign sda_line = m_sda & !(sda_oe_o & !sda_o);
    always #25 mclk_i = ~mclk_i;

    two_wire_eeprom_slave #(.ADDR_W(AW), .WR_CYCLES(WRC)) u_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .chip_select_bit2_i(straps_q[2]),
        .chip_select_bit1_i(straps_q[1]), .chip_select_bit0_i(straps_q[0]),
        .write_protect_i(protect_q), .write_busy_o(write_busy_o));
    bus_master u_master (.sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Write-direction device byte and two word-address bytes
    task automatic addr_cmd(input logic [15:0] a);
        u_master.start();
        u_master.send(8'hAA, ack);
        `CHK(ack, 1'b1)
        u_master.send(a[15:8], ack);
        `CHK(ack, 1'b1)
        u_master.send(a[7:0], ack);
        `CHK(ack, 1'b1)
    endtask

    // Poll until the write cycle is over, bounded
    task automatic wait_ready();
        ack = 1'b0;
        for (int i = 0; i < 40 && !ack; i++) begin
            u_master.start();
            u_master.send(8'hAA, ack);
            u_master.stop();
        end
        `CHK(ack, 1'b1)
    endtask

    // Page write of n bytes; model keeps page row fixed
    task automatic write_page(input logic [15:0] a, input int n, input logic [7:0] v0);
        logic [7:0] d;
        wait_ready();
        addr_cmd(a);
        for (int i = 0; i < n; i++) begin
            d = v0 + 8'(i);
            u_master.send(d, ack);
            `CHK(ack, 1'b1)
            if (!protect_q) ref_mem[{a[14:6], 6'(a[5:0] + 6'(i))}] = d;
        end
        u_master.stop();
        repeat (20) @(posedge mclk_i);
        #5;
        `CHK(write_busy_o, !protect_q)
        u_master.start();
        u_master.send(8'hAA, ack);
        u_master.stop();
        `CHK(ack, protect_q)
    endtask

    // Random or current-address read; last byte refused
    task automatic read_seq(input logic rnd, input logic [15:0] a, input int n);
        int cur;
        wait_ready();
        cur = rnd ? int'(a[14:0]) : cur_q;
        if (rnd) addr_cmd(a);
        u_master.start();
        u_master.send(8'hAB, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            u_master.recv(i < n - 1, rd);
            `CHK(rd, ref_mem[cur])
            cur = (cur + 1) % (1 << AW);
        end
        u_master.stop();
        cur_q = cur;
        `CHK(write_busy_o, 1'b0)
    endtask

    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        #5;
        `CHK(sda_oe_o, 1'b0)
        `CHK(write_busy_o, 1'b0)
        // Address byte table
        foreach (rows[i]) begin
            u_master.start();
            u_master.send(rows[i][8:1], ack);
            `CHK(ack, rows[i][0])
            if (ack && rows[i][1]) u_master.recv(1'b0, rd);
            u_master.stop();
        end
        // 66 bytes overrun the page; extra top address bit
        write_page(16'h8123, 66, 8'h10);
        read_seq(1'b1, 16'h0100, 40);
        read_seq(1'b0, 16'h0000, 1);
        @(posedge mclk_i) protect_q <= 1'b1;
        write_page(16'h0100, 1, 8'h5A);
        @(posedge mclk_i) protect_q <= 1'b0;
        read_seq(1'b1, 16'h0100, 1);
        // Data byte left pending, then a new start must drop it
        addr_cmd(16'h0100);
        u_master.send(8'hEE, ack);
        `CHK(ack, 1'b1)
        read_seq(1'b1, 16'h0100, 1);
        write_page(16'h7FFF, 1, 8'hC3);
        write_page(16'h0000, 1, 8'h3C);
        read_seq(1'b1, 16'h7FFF, 2);
        // Mid-run reset: outputs quiet, counter back to zero, array kept
        @(posedge mclk_i) srst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        #5;
        `CHK(sda_oe_o, 1'b0)
        `CHK(write_busy_o, 1'b0)
        cur_q = 0;
        read_seq(1'b0, 16'h0000, 1);
        finish_test();
    end

    // Watchdog, about three times the expected run
    initial begin
        #2000000;
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule // tb_top
